//--- rtl/cam_pkg.sv
package cam_pkg;

   localparam int ADDR_W    = 32;
   localparam int WORD_W    = 16;
   localparam int BANK_W    = 2;
   localparam int PC_RST    = 0;
   localparam int SP_RST    = 0;
   localparam int ADDR_STEP = 2;

   typedef enum logic [4:0]
   {
      OP_NOP      = 5'b0_0000,
      OP_SET_EXT  = 5'b0_0001,
      OP_SET_LONG = 5'b0_0010,
      OP_CLR_LONG = 5'b0_0011,
      OP_CTL_LOAD = 5'b0_0100,
      OP_DIR_WORD = 5'b0_0101,
      OP_DIR_LONG = 5'b0_0110,
      OP_ADDR_ADD = 5'b0_0111,
      OP_ADDR_SUB = 5'b0_1000,
      OP_PC_INC   = 5'b0_1001,
      OP_SP_PUSH  = 5'b0_1010,
      OP_SP_POP   = 5'b0_1011,
      OP_SP_LOAD  = 5'b0_1100,
      OP_LD_WORD  = 5'b0_1101,
      OP_EX_WORD  = 5'b0_1110,
      OP_ALU      = 5'b0_1111,
      OP_MUL      = 5'b1_0000,
      OP_DIV      = 5'b1_0001,
      OP_IO_WORD  = 5'b1_0010
   } cam_op_e;

   typedef enum logic [2:0]
   {
      ALU_ADD = 3'b000,
      ALU_SUB = 3'b001,
      ALU_AND = 3'b010,
      ALU_OR  = 3'b011,
      ALU_XOR = 3'b100,
      ALU_SHL = 3'b101,
      ALU_SHR = 3'b110,
      ALU_ROL = 3'b111
   } cam_alu_e;

   // one instruction as handed over by the decoder
   typedef struct packed
   {
      cam_op_e           op;
      cam_alu_e          alu_fn;
      logic [ADDR_W-1:0] src;
      logic [ADDR_W-1:0] dst;
   } cam_instr_s;

   // control select register contents
   typedef struct packed
   {
      logic [BANK_W-1:0] bank;
      logic              long_word_bit;
      logic              extended_address_bit;
   } cam_mode_s;

   localparam cam_mode_s MODE_RST = '{bank: '0, long_word_bit: 1'b0, extended_address_bit: 1'b0};

endpackage

//--- rtl/cam_mode_core.sv
`timescale 1ns/1ps
module cam_mode_core
(
   // clock and reset
   input  wire logic                            core_clk,
   input  wire logic                            rst_n,
   // instruction from decoder
   input  wire logic                            instr_valid,
   input  wire cam_pkg::cam_instr_s             instr,
   // mode state
   output cam_pkg::cam_mode_s                   mode_select_register,
   output logic                                 extended_address_bit,
   output logic                                 long_word_bit,
   output logic                                 directive_pending,
   // address side
   output logic [cam_pkg::ADDR_W-1:0]           pc_q,
   output logic [cam_pkg::ADDR_W-1:0]           sp_q,
   output logic [cam_pkg::ADDR_W-1:0]           addr_bus,
   // data side
   output logic [cam_pkg::ADDR_W-1:0]           dst_out,
   output logic [cam_pkg::ADDR_W-1:0]           src_out,
   output logic [cam_pkg::WORD_W-1:0]           alu_out,
   output logic [cam_pkg::ADDR_W-1:0]           muldiv_out,
   output logic [cam_pkg::WORD_W-1:0]           io_data,
   output logic                                 done
);

   localparam logic [cam_pkg::ADDR_W-1:0] STEP = cam_pkg::ADDR_W'(cam_pkg::ADDR_STEP);
   localparam int W = cam_pkg::WORD_W;

   logic                        rst_s1_q;
   logic                        rst_s2_q;
   cam_pkg::cam_mode_s          mode_q;
   logic                        dir_valid_q;
   logic                        dir_long_q;
   logic [cam_pkg::ADDR_W-1:0]  pc_d;
   logic [cam_pkg::ADDR_W-1:0]  sp_d;
   logic [cam_pkg::ADDR_W-1:0]  addr_q;
   logic [cam_pkg::ADDR_W-1:0]  dst_q;
   logic [cam_pkg::ADDR_W-1:0]  src_q;
   logic [W-1:0]                alu_q;
   logic [cam_pkg::ADDR_W-1:0]  md_q;
   logic [W-1:0]                io_q;
   logic                        done_q;
   logic [cam_pkg::ADDR_W-1:0]  pc_q_r;
   logic [cam_pkg::ADDR_W-1:0]  sp_q_r;
   logic                        eff_long;
   logic                        is_dir;
   logic [W-1:0]                alu_d;

   // address arithmetic width follows the address mode bit
   function automatic logic [cam_pkg::ADDR_W-1:0] addr_arith
   (
      input logic                       ext,
      input logic [cam_pkg::ADDR_W-1:0] base,
      input logic [cam_pkg::ADDR_W-1:0] delta,
      input logic                       sub
   );
      logic [cam_pkg::ADDR_W-1:0] full;
      full = sub ? base - delta : base + delta;
      if (ext)
      begin
         addr_arith = full;
      end
      else
      begin
         addr_arith = {base[cam_pkg::ADDR_W-1:W], full[W-1:0]};
      end
   endfunction

   // word move: low word only unless long
   function automatic logic [cam_pkg::ADDR_W-1:0] word_move
   (
      input logic                       lng,
      input logic [cam_pkg::ADDR_W-1:0] from,
      input logic [cam_pkg::ADDR_W-1:0] into
   );
      if (lng)
      begin
         word_move = from;
      end
      else
      begin
         word_move = {into[cam_pkg::ADDR_W-1:W], from[W-1:0]};
      end
   endfunction

   // the design only ever sees the synchronised reset release
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   assign is_dir   = instr.op == cam_pkg::OP_DIR_WORD || instr.op == cam_pkg::OP_DIR_LONG;
   assign eff_long = dir_valid_q ? dir_long_q : mode_q.long_word_bit;

   // select register
   always_ff @(posedge core_clk or negedge rst_s2_q)
   begin
      if (!rst_s2_q)
      begin
         mode_q <= cam_pkg::MODE_RST;
      end
      else if (instr_valid)
      begin
         case (instr.op)
            cam_pkg::OP_SET_EXT:  mode_q.extended_address_bit <= 1'b1;
            cam_pkg::OP_SET_LONG: mode_q.long_word_bit <= 1'b1;
            cam_pkg::OP_CLR_LONG: mode_q.long_word_bit <= 1'b0;
            // control load only reaches the register-set field; the mode bits keep their own paths
            cam_pkg::OP_CTL_LOAD: mode_q.bank <= instr.src[cam_pkg::BANK_W-1:0];
            default:            mode_q <= mode_q;
         endcase
      end
   end

   // decoder directive lives for exactly one following instruction
   always_ff @(posedge core_clk or negedge rst_s2_q)
   begin
      if (!rst_s2_q)
      begin
         dir_valid_q <= 1'b0;
         dir_long_q  <= 1'b0;
      end
      else if (instr_valid)
      begin
         dir_valid_q <= is_dir;
         dir_long_q  <= instr.op == cam_pkg::OP_DIR_LONG;
      end
   end

   // program counter and stack pointer
   always_comb
   begin
      pc_d = pc_q_r;
      sp_d = sp_q_r;
      if (instr_valid)
      begin
         case (instr.op)
            cam_pkg::OP_PC_INC:  pc_d = addr_arith(mode_q.extended_address_bit, pc_q_r, STEP, 1'b0);
            cam_pkg::OP_SP_PUSH: sp_d = addr_arith(mode_q.extended_address_bit, sp_q_r, STEP, 1'b1);
            cam_pkg::OP_SP_POP:  sp_d = addr_arith(mode_q.extended_address_bit, sp_q_r, STEP, 1'b0);
            cam_pkg::OP_SP_LOAD: sp_d = instr.src;
            default:
            begin
               pc_d = pc_q_r;
               sp_d = sp_q_r;
            end
         endcase
      end
      if (!mode_q.extended_address_bit)
      begin
         pc_d[cam_pkg::ADDR_W-1:W] = '0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_s2_q)
   begin
      if (!rst_s2_q)
      begin
         pc_q_r <= cam_pkg::ADDR_W'(cam_pkg::PC_RST);
         sp_q_r <= cam_pkg::ADDR_W'(cam_pkg::SP_RST);
      end
      else
      begin
         pc_q_r <= pc_d;
         sp_q_r <= sp_d;
      end
   end

   // external address: all 32 bits, direct addresses pass unchanged
   always_ff @(posedge core_clk or negedge rst_s2_q)
   begin
      if (!rst_s2_q)
      begin
         addr_q <= '0;
      end
      else if (instr_valid)
      begin
         case (instr.op)
            cam_pkg::OP_ADDR_ADD: addr_q <= addr_arith(extended_address_bit, instr.src, instr.dst, 1'b0);
            cam_pkg::OP_ADDR_SUB: addr_q <= addr_arith(extended_address_bit, instr.src, instr.dst, 1'b1);
            cam_pkg::OP_PC_INC:   addr_q <= pc_q_r;
            default:              addr_q <= addr_q;
         endcase
      end
   end

   // word loads and exchanges
   always_ff @(posedge core_clk or negedge rst_s2_q)
   begin
      if (!rst_s2_q)
      begin
         dst_q <= '0;
         src_q <= '0;
      end
      else if (instr_valid && instr.op == cam_pkg::OP_LD_WORD)
      begin
         dst_q <= word_move(eff_long, instr.src, instr.dst);
         src_q <= instr.src;
      end
      else if (instr_valid && instr.op == cam_pkg::OP_EX_WORD)
      begin
         dst_q <= word_move(eff_long, instr.src, instr.dst);
         src_q <= word_move(eff_long, instr.dst, instr.src);
      end
   end

   // word alu is 16 bits whatever the modes say
   always_comb
   begin
      case (instr.alu_fn)
         cam_pkg::ALU_ADD: alu_d = instr.src[W-1:0] + instr.dst[W-1:0];
         cam_pkg::ALU_SUB: alu_d = instr.src[W-1:0] - instr.dst[W-1:0];
         cam_pkg::ALU_AND: alu_d = instr.src[W-1:0] & instr.dst[W-1:0];
         cam_pkg::ALU_OR:  alu_d = instr.src[W-1:0] | instr.dst[W-1:0];
         cam_pkg::ALU_XOR: alu_d = instr.src[W-1:0] ^ instr.dst[W-1:0];
         cam_pkg::ALU_SHL: alu_d = {instr.src[W-2:0], 1'b0};
         cam_pkg::ALU_SHR: alu_d = {1'b0, instr.src[W-1:1]};
         default:          alu_d = {instr.src[W-2:0], instr.src[W-1]};
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_s2_q)
   begin
      if (!rst_s2_q)
      begin
         alu_q <= '0;
      end
      else if (instr_valid && instr.op == cam_pkg::OP_ALU)
      begin
         alu_q <= alu_d;
      end
   end

   // multiply and divide; divide by zero returns all ones rather than trapping
   always_ff @(posedge core_clk or negedge rst_s2_q)
   begin
      if (!rst_s2_q)
      begin
         md_q <= '0;
      end
      else if (instr_valid && instr.op == cam_pkg::OP_MUL)
      begin
         md_q <= cam_pkg::ADDR_W'(instr.src[W-1:0]) * cam_pkg::ADDR_W'(instr.dst[W-1:0]);
      end
      else if (instr_valid && instr.op == cam_pkg::OP_DIV)
      begin
         if (instr.dst[W-1:0] == '0)
         begin
            md_q <= '1;
         end
         else
         begin
            md_q <= instr.src / {16'h0000, instr.dst[W-1:0]};
         end
      end
   end

   // word i/o ignores the long word bit
   always_ff @(posedge core_clk or negedge rst_s2_q)
   begin
      if (!rst_s2_q)
      begin
         io_q <= '0;
      end
      else if (instr_valid && instr.op == cam_pkg::OP_IO_WORD)
      begin
         io_q <= instr.src[W-1:0];
      end
   end

   always_ff @(posedge core_clk or negedge rst_s2_q)
   begin
      if (!rst_s2_q)
      begin
         done_q <= 1'b0;
      end
      else
      begin
         done_q <= instr_valid;
      end
   end

   assign mode_select_register = mode_q;
   assign extended_address_bit = mode_q.extended_address_bit;
   assign long_word_bit        = mode_q.long_word_bit;
   assign directive_pending    = dir_valid_q;
   assign pc_q                 = pc_q_r;
   assign sp_q                 = sp_q_r;
   assign addr_bus             = addr_q;
   assign dst_out              = dst_q;
   assign src_out              = src_q;
   assign alu_out              = alu_q;
   assign muldiv_out           = md_q;
   assign io_data              = io_q;
   assign done                 = done_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_s2_q);

   AST_EXT_STICKY: assert property (extended_address_bit |=> extended_address_bit)
      else $error("extended mode left without reset");
   AST_EXT_SET: assert property (instr_valid && instr.op == cam_pkg::OP_SET_EXT |=> extended_address_bit)
      else $error("set extended did not take");
   AST_LONG_HOLD: assert property (!(instr_valid && instr.op == cam_pkg::OP_SET_LONG)
      && !(instr_valid && instr.op == cam_pkg::OP_CLR_LONG) |=> $stable(long_word_bit))
      else $error("long word bit moved without instruction");
   AST_LONG_CLR: assert property (instr_valid && instr.op == cam_pkg::OP_CLR_LONG |=> !long_word_bit)
      else $error("clear long word did not take");
   AST_PC_NATIVE: assert property (!extended_address_bit |=> pc_q[31:16] == 16'h0000 || extended_address_bit)
      else $error("pc upper word nonzero in native mode");
   AST_PC_WRAP: assert property (!extended_address_bit && instr_valid && instr.op == cam_pkg::OP_PC_INC
      && pc_q[15:0] == 16'hFFFE |=> pc_q == 32'h0000_0000)
      else $error("native pc did not wrap at 64k");
   AST_SP_UPPER: assert property (!extended_address_bit && instr_valid && instr.op == cam_pkg::OP_SP_PUSH
      |=> sp_q[31:16] == $past(sp_q[31:16]))
      else $error("native stack arithmetic changed upper word");
   AST_SP_EXT: assert property (extended_address_bit && instr_valid && instr.op == cam_pkg::OP_SP_POP
      |=> sp_q == $past(sp_q) + 32'h0000_0002)
      else $error("extended stack arithmetic not 32 bits");
   AST_EX_WORD: assert property (instr_valid && instr.op == cam_pkg::OP_EX_WORD && !eff_long
      |=> dst_out[31:16] == $past(instr.dst[31:16]) && src_out[31:16] == $past(instr.src[31:16]))
      else $error("word exchange touched upper words");
   AST_DIR_ONCE: assert property (directive_pending && instr_valid && !is_dir |=> !directive_pending)
      else $error("directive outlived its instruction");
   AST_DIR_GLOBAL: assert property (instr_valid && is_dir |=> directive_pending && $stable(long_word_bit))
      else $error("directive changed the global long word bit");
   AST_IO16: assert property (instr_valid && instr.op == cam_pkg::OP_IO_WORD
      |=> io_data == $past(instr.src[15:0]))
      else $error("word io value wrong");

   COV_EXT: cover property (instr_valid && instr.op == cam_pkg::OP_SET_EXT ##1 extended_address_bit);
   COV_DIR: cover property (instr_valid && instr.op == cam_pkg::OP_DIR_LONG
      ##[1:2] instr_valid && instr.op == cam_pkg::OP_EX_WORD);
   COV_LONG: cover property (long_word_bit ##1 instr_valid && instr.op == cam_pkg::OP_LD_WORD);

endmodule

//--- test/cam_mem_model.sv
`timescale 1ns/1ps
// far side of the address bus: latches every address the core hands out
module cam_mem_model
(
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   // address bus from the core
   input  wire logic [31:0]           addr_bus,
   input  wire logic                  done,
   // last address seen
   output logic      [31:0]           last_addr_q
);
   // all 32 lines captured, so a dropped upper word shows up here too
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         last_addr_q <= 32'h0000_0000;
      else if (done)
         last_addr_q <= addr_bus;
   end
endmodule

//--- test/test_cam_mode_core.sv
`timescale 1ns/1ps
module test_cam_mode_core;
   logic                   core_clk = 1'b0;
   logic                   rst_n    = 1'b0;
   logic                   instr_valid = 1'b0;
   cam_pkg::cam_instr_s    instr = '0;
   cam_pkg::cam_mode_s     mode_select_register;
   logic                   extended_address_bit;
   logic                   long_word_bit;
   logic                   directive_pending;
   logic [31:0]            pc_q;
   logic [31:0]            sp_q;
   logic [31:0]            addr_bus;
   logic [31:0]            dst_out;
   logic [31:0]            src_out;
   logic [15:0]            alu_out;
   logic [31:0]            muldiv_out;
   logic [15:0]            io_data;
   logic                   done;
   logic [31:0]            last_addr_q;
   int                     fails = 0;
   int                     comparisons = 0;

   always #12.5 core_clk = ~core_clk;

   cam_mode_core dut_u
   (
      .core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
      .mode_select_register(mode_select_register), .extended_address_bit(extended_address_bit),
      .long_word_bit(long_word_bit), .directive_pending(directive_pending), .pc_q(pc_q), .sp_q(sp_q),
      .addr_bus(addr_bus), .dst_out(dst_out), .src_out(src_out), .alu_out(alu_out),
      .muldiv_out(muldiv_out), .io_data(io_data), .done(done)
   );

   cam_mem_model mem_u
   (
      .core_clk(core_clk), .rst_n(rst_n), .addr_bus(addr_bus), .done(done), .last_addr_q(last_addr_q)
   );

   task automatic print_verdict;
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one instruction, then wait (bounded) for its done pulse; results are read at that negedge
   task automatic issue(input cam_pkg::cam_op_e op, input logic [31:0] s, input logic [31:0] d,
                        input cam_pkg::cam_alu_e f = cam_pkg::ALU_ADD);
      int n;
      @(posedge core_clk);
      instr_valid <= 1'b1;
      instr       <= '{op: op, alu_fn: f, src: s, dst: d};
      @(posedge core_clk);
      instr_valid <= 1'b0;
      n = 0;
      @(negedge core_clk);
      while (done !== 1'b1 && n < 8)
      begin
         @(negedge core_clk);
         n++;
      end
      if (n == 8)
      begin
         fails++;
         $display("CHECK FAILED done expected 1 seen %b", done);
         print_verdict();
      end
   endtask

   task automatic do_reset(input int cycles);
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (cycles) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
   endtask

   task automatic check_modes(input logic ext, input logic lng, input logic [1:0] bank);
      chk("ext_bit", {31'h0, ext}, {31'h0, extended_address_bit});
      chk("long_bit", {31'h0, lng}, {31'h0, long_word_bit});
      chk("mode_reg", {28'h0, bank, lng, ext}, {28'h0, mode_select_register});
   endtask

   task automatic scen_reset;
      check_modes(1'b0, 1'b0, 2'b00);
      chk("pc", 32'h0000_0000, pc_q);
      chk("sp", 32'h0000_0000, sp_q);
   endtask

   task automatic scen_native_addr;
      issue(cam_pkg::OP_PC_INC, 32'h0, 32'h0);
      chk("pc", 32'h0000_0002, pc_q);
      chk("addr", 32'h0000_0000, addr_bus);
      issue(cam_pkg::OP_SP_LOAD, 32'h0001_FFFE, 32'h0);
      chk("sp", 32'h0001_FFFE, sp_q);
      issue(cam_pkg::OP_SP_POP, 32'h0, 32'h0);
      chk("sp", 32'h0001_0000, sp_q);
      issue(cam_pkg::OP_SP_PUSH, 32'h0, 32'h0);
      chk("sp", 32'h0001_FFFE, sp_q);
      issue(cam_pkg::OP_ADDR_ADD, 32'h1234_FFFF, 32'h0000_0002);
      chk("addr", 32'h1234_0001, addr_bus);
      @(negedge core_clk);
      chk("mem_addr", 32'h1234_0001, last_addr_q);
      issue(cam_pkg::OP_ADDR_SUB, 32'hABCD_0001, 32'h0000_0002);
      chk("addr", 32'hABCD_FFFF, addr_bus);
   endtask

   // back to back increments: 32767 steps of 2 from pc 2 must wrap the low word to zero
   task automatic scen_pc_wrap;
      @(posedge core_clk);
      instr_valid <= 1'b1;
      instr       <= '{op: cam_pkg::OP_PC_INC, alu_fn: cam_pkg::ALU_ADD, src: 32'h0000_0000, dst: 32'h0000_0000};
      repeat (32767) @(posedge core_clk);
      instr_valid <= 1'b0;
      @(negedge core_clk);
      chk("pc_wrap", 32'h0000_0000, pc_q);
      chk("addr_wrap", 32'h0000_FFFE, addr_bus);
   endtask

   task automatic scen_word_moves;
      issue(cam_pkg::OP_LD_WORD, 32'hAAAA_5555, 32'h1111_2222);
      chk("ld_dst", 32'h1111_5555, dst_out);
      issue(cam_pkg::OP_EX_WORD, 32'hAAAA_5555, 32'h1111_2222);
      chk("ex_dst", 32'h1111_5555, dst_out);
      chk("ex_src", 32'hAAAA_2222, src_out);
      issue(cam_pkg::OP_DIR_LONG, 32'h0, 32'h0);
      chk("pending", 32'h1, {31'h0, directive_pending});
      issue(cam_pkg::OP_EX_WORD, 32'hAAAA_5555, 32'h1111_2222);
      chk("ex_dst", 32'hAAAA_5555, dst_out);
      chk("ex_src", 32'h1111_2222, src_out);
      chk("long_bit", 32'h0, {31'h0, long_word_bit});
      issue(cam_pkg::OP_EX_WORD, 32'h3333_4444, 32'h5555_6666);
      chk("ex_dst", 32'h5555_4444, dst_out);
      issue(cam_pkg::OP_SET_LONG, 32'h0, 32'h0);
      check_modes(1'b0, 1'b1, 2'b00);
      issue(cam_pkg::OP_NOP, 32'h0, 32'h0);
      issue(cam_pkg::OP_LD_WORD, 32'hAAAA_5555, 32'h1111_2222);
      chk("ld_dst", 32'hAAAA_5555, dst_out);
      issue(cam_pkg::OP_DIR_WORD, 32'h0, 32'h0);
      issue(cam_pkg::OP_EX_WORD, 32'hAAAA_5555, 32'h1111_2222);
      chk("ex_src", 32'hAAAA_2222, src_out);
      chk("long_bit", 32'h1, {31'h0, long_word_bit});
      issue(cam_pkg::OP_EX_WORD, 32'h3333_4444, 32'h5555_6666);
      chk("ex_src", 32'h5555_6666, src_out);
   endtask

   // long-word mode stays on here: arithmetic and io widths must ignore it
   task automatic scen_arith;
      cam_pkg::cam_alu_e fn [7] = '{cam_pkg::ALU_ADD, cam_pkg::ALU_SUB, cam_pkg::ALU_AND, cam_pkg::ALU_OR,
                                    cam_pkg::ALU_XOR, cam_pkg::ALU_SHL, cam_pkg::ALU_SHR};
      logic [15:0]       ex [7] = '{16'h4004, 16'hBFFE, 16'h8001, 16'hC003, 16'h4002, 16'h0002, 16'h4000};
      for (int i = 0; i < 7; i++)
      begin
         issue(cam_pkg::OP_ALU, 32'hFFFF_8001, 32'hFFFF_C003, fn[i]);
         chk("alu", {16'h0, ex[i]}, {16'h0, alu_out});
      end
      issue(cam_pkg::OP_ALU, 32'hFFFF_8001, 32'h0, cam_pkg::ALU_ROL);
      chk("alu_rol", 32'h0000_0003, {16'h0, alu_out});
      issue(cam_pkg::OP_MUL, 32'h0000_FFFF, 32'h0000_FFFF);
      chk("mul", 32'hFFFE_0001, muldiv_out);
      issue(cam_pkg::OP_DIV, 32'h0012_3456, 32'h0000_0010);
      chk("div", 32'h0001_2345, muldiv_out);
      issue(cam_pkg::OP_DIV, 32'h0012_3456, 32'h0000_0000);
      chk("div0", 32'hFFFF_FFFF, muldiv_out);
      issue(cam_pkg::OP_IO_WORD, 32'hABCD_1234, 32'h0);
      chk("io", 32'h0000_1234, {16'h0, io_data});
      issue(cam_pkg::OP_CLR_LONG, 32'h0, 32'h0);
      check_modes(1'b0, 1'b0, 2'b00);
   endtask

   task automatic scen_extended;
      issue(cam_pkg::OP_SET_EXT, 32'h0, 32'h0);
      check_modes(1'b1, 1'b0, 2'b00);
      issue(cam_pkg::OP_ADDR_ADD, 32'h1234_FFFF, 32'h0000_0002);
      chk("addr", 32'h1235_0001, addr_bus);
      issue(cam_pkg::OP_SP_POP, 32'h0, 32'h0);
      chk("sp", 32'h0002_0000, sp_q);
      issue(cam_pkg::OP_CLR_LONG, 32'h0, 32'h0);
      issue(cam_pkg::OP_CTL_LOAD, 32'h0000_0003, 32'h0);
      check_modes(1'b1, 1'b0, 2'b11);
      do_reset(2);
      check_modes(1'b0, 1'b0, 2'b00);
   endtask

   initial
   begin
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      scen_reset();
      scen_native_addr();
      scen_pc_wrap();
      scen_word_moves();
      scen_arith();
      scen_extended();
      print_verdict();
   end
endmodule
